// ---- rtl/mise_core.sv ----
// Executor for a subset of an 8-bit microcontroller instruction set
// What this block does
// RULE1: Power-down stops execution and system clock
// RULE2: Power-down keeps data, clears watchdog
// RULE3: Power-down sets powered-down, clears watchdog-expired unless an expiry arrives in that cycle
// RULE4: Memory increment writes sum back, updates zero
// RULE5: Increment into working register, memory untouched
// RULE6: Goto loads program counter, flags untouched
// RULE7: Goto takes two cycles with dummy
// RULE8: Memory to working register, flags untouched
// RULE9: Immediate to working register, flags untouched
// RULE10: Working register to memory, flags untouched
// RULE11: Other instructions single cycle, counter advances
// RULE12: Zero flag set when incremented byte wraps
`timescale 1ns/1ns
`default_nettype none
module mise_core
   import mise_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // Instruction presented for the current cycle
   input  wire logic              op_valid,
   input  wire logic [2:0]        op_code,
   input  wire logic [ADDR_W-1:0] op_mem_addr,
   input  wire logic [DATA_W-1:0] op_imm,
   input  wire logic [PC_W-1:0]   op_target,
   // Wake-up from power-down
   input  wire logic              wake_up,
   // Watchdog expiry event from the watchdog block
   input  wire logic              watchdog_timeout,
   // Status and state
   output logic [PC_W-1:0]        pc,
   output logic [DATA_W-1:0]      working_register,
   output logic                   zero_flag,
   output logic                   powered_down_flag,
   output logic                   watchdog_expired_flag,
   output logic                   watchdog_clear,
   output logic                   sys_clk_en,
   output logic                   fetch_en,
   output logic                   dummy_cycle,
   // Data memory read and write port
   input  wire logic [DATA_W-1:0] mem_rd_data,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_wr_en,
   output logic [DATA_W-1:0]      mem_wr_data
);

   // Whole state in one registered copy
   mise_regs_t        r_reg;
   mise_regs_t        r_next;
   // Decoded instruction and increment result
   mise_op_t          op;
   logic              op_taken;
   logic [DATA_W-1:0] sum;
   logic              sum_is_zero;

   // Reset image: counter at start, all flags clear, running
   localparam mise_regs_t REGS_AT_RESET = '{
      state:            MISE_RUN,
      pc:               PC_RESET,
      working:          ZERO_BYTE,
      zero:             1'b0,
      powered_down:     1'b0,
      watchdog_expired: 1'b0,
      wdog_clear:       1'b0
   };

   // Byte increment; the top value wraps to zero
   function automatic logic [DATA_W-1:0] plus_one(input logic [DATA_W-1:0] v);
      plus_one = v + ONE_BYTE;
   endfunction : plus_one

   // Zero test on a byte result
   function automatic logic byte_is_zero(input logic [DATA_W-1:0] v);
      byte_is_zero = (v == ZERO_BYTE);
   endfunction : byte_is_zero

   // Next sequential program address
   function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] p);
      next_pc = p + PC_ONE;
   endfunction : next_pc

   // Ops whose result feeds the zero flag
   function automatic logic sets_zero(input mise_op_t o);
      case (o)
         MISE_OP_INC_MEM: begin
            sets_zero = 1'b1;
         end
         MISE_OP_INC_WORK: begin
            sets_zero = 1'b1;
         end
         default: begin
            sets_zero = 1'b0;
         end
      endcase
   endfunction : sets_zero

   // Ops that store into data memory
   function automatic logic writes_mem(input mise_op_t o);
      case (o)
         MISE_OP_INC_MEM: begin
            writes_mem = 1'b1;
         end
         MISE_OP_W_TO_MEM: begin
            writes_mem = 1'b1;
         end
         default: begin
            writes_mem = 1'b0;
         end
      endcase
   endfunction : writes_mem

   // Working register after an op; only moves and one increment load it
   function automatic logic [DATA_W-1:0] working_after(
      input mise_op_t          o,
      input logic [DATA_W-1:0] cur,
      input logic [DATA_W-1:0] inc,
      input logic [DATA_W-1:0] rd,
      input logic [DATA_W-1:0] imm
   );
      case (o)
         MISE_OP_INC_WORK: begin
            working_after = inc; // RULE5
         end
         MISE_OP_MEM_TO_W: begin
            working_after = rd; // RULE8
         end
         MISE_OP_IMM_TO_W: begin
            working_after = imm; // RULE9
         end
         default: begin
            working_after = cur;
         end
      endcase
   endfunction : working_after

   // Instruction decode
   assign op          = mise_op_t'(op_code);
   assign op_taken    = op_valid && (r_reg.state == MISE_RUN); // RULE1 RULE7
   assign sum         = plus_one(mem_rd_data); // RULE4 RULE5
   assign sum_is_zero = byte_is_zero(sum); // RULE12

   // Memory port; write data is combinational so a store lands in its own cycle
   always_comb begin
      mem_addr    = op_mem_addr;
      mem_wr_en   = op_taken && writes_mem(op); // RULE2 RULE4 RULE10
      mem_wr_data = r_reg.working; // RULE10
      if (op == MISE_OP_INC_MEM) begin
         mem_wr_data = sum; // RULE4
      end
   end

   always_comb begin
      r_next            = r_reg;
      r_next.wdog_clear = 1'b0;
      // Expiry event wins over a power-down clear in the same cycle
      if (watchdog_timeout) begin
         r_next.watchdog_expired = 1'b1;
      end
      case (r_reg.state)
         MISE_RUN: begin
            if (op_valid) begin
               r_next.pc      = next_pc(r_reg.pc); // RULE11
               r_next.working = working_after(op, r_reg.working, sum, mem_rd_data, op_imm);
               if (sets_zero(op)) begin
                  r_next.zero = sum_is_zero; // RULE12
               end
               case (op)
                  MISE_OP_POWERDOWN: begin
                     r_next.state        = MISE_SLEEP; // RULE1
                     r_next.wdog_clear   = 1'b1; // RULE2
                     r_next.powered_down = 1'b1; // RULE3
                     if (!watchdog_timeout) begin
                        r_next.watchdog_expired = 1'b0; // RULE3
                     end
                  end
                  MISE_OP_GOTO: begin
                     r_next.pc    = op_target; // RULE6
                     r_next.state = MISE_DUMMY; // RULE7
                  end
                  default: begin
                  end
               endcase
            end
         end
         // Second cycle of goto; the word fetched meanwhile is dropped
         MISE_DUMMY: begin
            r_next.state = MISE_RUN; // RULE7
         end
         // Clock held off; only a wake-up resumes the core
         MISE_SLEEP: begin
            if (wake_up) begin
               r_next.state = MISE_RUN; // RULE1
            end
         end
         default: begin
            r_next.state = MISE_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_reg <= REGS_AT_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs from the registered copy; clear pulse lags power-down by one
   assign pc                    = r_reg.pc;
   assign working_register      = r_reg.working;
   assign zero_flag             = r_reg.zero;
   assign powered_down_flag     = r_reg.powered_down;
   assign watchdog_expired_flag = r_reg.watchdog_expired;
   assign watchdog_clear        = r_reg.wdog_clear; // RULE2
   assign sys_clk_en            = (r_reg.state != MISE_SLEEP); // RULE1
   assign fetch_en              = (r_reg.state == MISE_RUN); // RULE1
   assign dummy_cycle           = (r_reg.state == MISE_DUMMY); // RULE7

endmodule : mise_core
`default_nettype wire

// ---- rtl/mise_pkg.sv ----
// Package of constants and types for the instruction subset executor
package mise_pkg;
   localparam int unsigned DATA_W  = 8;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned PC_W    = 11;
   localparam int unsigned MEM_DEPTH = 256;

   localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [PC_W-1:0]   PC_ONE    = 11'h001;
   localparam logic [PC_W-1:0]   PC_RESET  = 11'h000;

   // Opcode encodings presented on op_code
   typedef enum logic [2:0] {
      MISE_OP_NONE      = 3'b000,
      MISE_OP_POWERDOWN = 3'b001,
      MISE_OP_INC_MEM   = 3'b010,
      MISE_OP_INC_WORK  = 3'b011,
      MISE_OP_GOTO      = 3'b100,
      MISE_OP_MEM_TO_W  = 3'b101,
      MISE_OP_IMM_TO_W  = 3'b110,
      MISE_OP_W_TO_MEM  = 3'b111
   } mise_op_t;

   typedef enum logic [1:0] {
      MISE_RUN   = 2'b00,
      MISE_DUMMY = 2'b01,
      MISE_SLEEP = 2'b10
   } mise_state_t;

   typedef struct packed {
      mise_state_t      state;
      logic [PC_W-1:0]  pc;
      logic [DATA_W-1:0] working;
      logic             zero;
      logic             powered_down;
      logic             watchdog_expired;
      logic             wdog_clear;
   } mise_regs_t;
endpackage : mise_pkg

// ---- verification/mise_core_props.sv ----
// Checker for the instruction subset executor
`timescale 1ns/1ns
`default_nettype none
module mise_props (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_b,
   // Instruction and events
   input wire logic        op_valid,
   input wire logic [2:0]  op_code,
   input wire logic [7:0]  op_imm,
   input wire logic [10:0] op_target,
   input wire logic        wake_up,
   input wire logic        watchdog_timeout,
   input wire logic [7:0]  mem_rd_data,
   // Watched outputs
   input wire logic [10:0] pc,
   input wire logic [7:0]  working_register,
   input wire logic        zero_flag,
   input wire logic        powered_down_flag,
   input wire logic        watchdog_expired_flag,
   input wire logic        watchdog_clear,
   input wire logic        sys_clk_en,
   input wire logic        fetch_en,
   input wire logic        dummy_cycle,
   input wire logic        mem_wr_en,
   input wire logic [7:0]  mem_wr_data
);
   // Taken op, fetch_en masks refused ones
   wire logic [3:0] t = {op_valid & fetch_en, op_code};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_pd_sleep: assert property (t == 4'h9 |=> powered_down_flag && watchdog_clear && !fetch_en)
      else $error("sleep entry wrong");
   a_inc_mem: assert property (t == 4'ha |-> mem_wr_en && mem_wr_data == mem_rd_data + 8'h01)
      else $error("increment write wrong");
   a_inc_work: assert property (t == 4'hb |-> !mem_wr_en ##1 working_register == $past(mem_rd_data) + 8'h01)
      else $error("increment to working wrong");
   a_zero_wrap: assert property (t[3:1] == 3'h5 |=> zero_flag == ($past(mem_rd_data) == 8'hff))
      else $error("zero flag wrong");
   a_goto_pc: assert property (t == 4'hc |=> pc == $past(op_target) && dummy_cycle ##1 !dummy_cycle && fetch_en)
      else $error("goto wrong");
   a_move_work: assert property (t == 4'hd |=> working_register == $past(mem_rd_data) && $stable(zero_flag))
      else $error("move wrong");
   a_imm_work: assert property (t == 4'he |=> working_register == $past(op_imm) && $stable(zero_flag))
      else $error("immediate move wrong");
   a_pd_expired: assert property (t == 4'h9 && !watchdog_timeout |=> !watchdog_expired_flag)
      else $error("expiry flag not cleared");
   a_sleep_hold: assert property (!sys_clk_en && !wake_up |=> !sys_clk_en && $stable(pc))
      else $error("sleep not held");
   a_store_mem: assert property (t == 4'hf |-> mem_wr_en && mem_wr_data == working_register)
      else $error("store wrong");
   a_pc_step: assert property (t[3] && t != 4'hc && t != 4'h8 |=> pc == $past(pc) + 11'h001)
      else $error("pc step wrong");
endmodule : mise_props
bind mise_core mise_props u_props (
   .ref_clk              (ref_clk),
   .rst_b                (rst_b),
   .op_valid             (op_valid),
   .op_code              (op_code),
   .op_imm               (op_imm),
   .op_target            (op_target),
   .wake_up              (wake_up),
   .watchdog_timeout     (watchdog_timeout),
   .mem_rd_data          (mem_rd_data),
   .pc                   (pc),
   .working_register     (working_register),
   .zero_flag            (zero_flag),
   .powered_down_flag    (powered_down_flag),
   .watchdog_expired_flag(watchdog_expired_flag),
   .watchdog_clear       (watchdog_clear),
   .sys_clk_en           (sys_clk_en),
   .fetch_en             (fetch_en),
   .dummy_cycle          (dummy_cycle),
   .mem_wr_en            (mem_wr_en),
   .mem_wr_data          (mem_wr_data)
);
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the instruction subset executor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        ref_clk = 0, rst_b = 0, op_valid = 0, wake_up = 0, watchdog_timeout = 0, zero_flag, fetch_en;
   logic        powered_down_flag, watchdog_expired_flag, watchdog_clear, sys_clk_en, dummy_cycle, mem_wr_en;
   logic        e_z = 0, e_pd = 0, e_wx = 0;
   logic [2:0]  op_code = 0;
   logic [7:0]  op_mem_addr = 0, op_imm = 0, mem_rd_data, working_register, mem_addr, mem_wr_data, e_w = 0, d;
   logic [10:0] op_target = 0, pc, e_pc = 0;
   logic [7:0]  mem [256];
   int          errors = 0, n_tests = 0;
   mise_core u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
      .op_mem_addr(op_mem_addr), .op_imm(op_imm), .op_target(op_target), .wake_up(wake_up),
      .watchdog_timeout(watchdog_timeout), .pc(pc), .working_register(working_register), .zero_flag(zero_flag),
      .powered_down_flag(powered_down_flag), .watchdog_expired_flag(watchdog_expired_flag),
      .watchdog_clear(watchdog_clear), .sys_clk_en(sys_clk_en), .fetch_en(fetch_en), .dummy_cycle(dummy_cycle),
      .mem_rd_data(mem_rd_data), .mem_addr(mem_addr), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data));
   always #50 ref_clk = ~ref_clk;
   // Memory answers in the same cycle
   assign mem_rd_data = mem[mem_addr];
   always @(posedge ref_clk) if (mem_wr_en) mem[mem_addr] <= mem_wr_data;
   function automatic logic [7:0] inc(input logic [7:0] v);
      return v + 8'h01;
   endfunction : inc
   task automatic chk(input logic [23:0] s, e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic st;
      chk({pc, working_register, zero_flag, powered_down_flag, watchdog_expired_flag}, {e_pc, e_w, e_z, e_pd, e_wx});
   endtask : st
   task automatic step(input logic [2:0] c);
      op_valid = 1;
      op_code = c;
      op_mem_addr = 8'($urandom);
      op_imm = 8'($urandom);
      op_target = 11'($urandom);
      #1 d = mem_rd_data;
      chk(mem_wr_en, c == 3'h2 || c == 3'h7);
      if (c == 3'h2 || c == 3'h7) chk(mem_wr_data, c[0] ? e_w : inc(d));
      e_pc = c == 3'h4 ? op_target : e_pc + 11'h001;
      if (c == 3'h1) {e_pd, e_wx} = {1'b1, watchdog_timeout};
      if (c[2:1] == 2'h1) e_z = inc(d) == 8'h00;
      if (c == 3'h3) e_w = inc(d);
      if (c == 3'h5) e_w = d;
      if (c == 3'h6) e_w = op_imm;
      @(negedge ref_clk);
      st();
      chk(mem[op_mem_addr], c == 3'h2 ? inc(d) : c == 3'h7 ? e_w : d);
      chk({fetch_en, dummy_cycle, watchdog_clear}, {c != 3'h1 && c != 3'h4, c == 3'h4, c == 3'h1});
      // Junk op while halted or in the dummy slot must be ignored
      if (c == 3'h1 || c == 3'h4) begin
         op_code = 3'($urandom);
         if (c == 3'h1) begin
            @(negedge ref_clk);
            chk(sys_clk_en, 1'b0);
            wake_up = 1;
         end
         @(negedge ref_clk);
         wake_up = 0;
         st();
      end
   endtask : step
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   initial begin
      void'($urandom(26981));
      // High seeds make increments wrap often
      foreach (mem[i]) mem[i] = 8'($urandom) | 8'hf0;
      repeat (16) @(negedge ref_clk);
      st();
      rst_b = 1;
      $display("reset test done");
      watchdog_timeout = 1;
      @(negedge ref_clk);
      watchdog_timeout = 0;
      e_wx = 1;
      st();
      step(3'h1);
      // Idle slot: nothing taken, counter and memory hold
      op_valid = 0;
      @(negedge ref_clk);
      chk(mem_wr_en, 1'b0);
      st();
      // Expiry in the power-down cycle wins over its clear
      watchdog_timeout = 1;
      step(3'h1);
      watchdog_timeout = 0;
      $display("sleep test done");
      repeat (300) step(3'h1 + 3'($urandom % 7));
      $display("random test done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
